// File: rtl/wdc_pkg.sv
// package: watchdog control register map, field layout, timing constants and bus carrier
package wdc_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned BASE_TICK_NS  = 1000;
  localparam int unsigned BASE_TICK_CYC = (BASE_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;

  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_CLR  = 8'h04;
  localparam logic [7:0]  OFS_SET  = 8'h08;
  localparam logic [7:0]  OFS_INV  = 8'h0c;

  localparam int unsigned BIT_ON   = 15;
  localparam int unsigned PS_LSB   = 2;
  localparam int unsigned PS_MSB   = 6;
  localparam int unsigned BIT_WIN  = 1;
  localparam int unsigned BIT_CLR  = 0;

  localparam logic [31:0] IMPL_MASK     = 32'h0000_807f;
  localparam logic        SW_EN_RESET   = 1'b0;
  localparam logic        WIN_RESET     = 1'b0;
  localparam logic [4:0]  PS_MAX        = 5'h14;
  localparam logic [7:0]  TICK_LAST     = 8'(BASE_TICK_CYC - 1);

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } wdc_apb_req_type;

endpackage : wdc_pkg

// File: rtl/wdc_counter.sv
// module: watchdog count, postscaler and window check
module wdc_counter (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       run_in,
  input  wire logic       clear_in,
  input  wire logic       window_in,
  input  wire logic [4:0] ps_in,
  output logic            expire_out,
  output logic            early_clear_out
);

  logic [7:0]  tick_r;
  logic [21:0] count_r;
  logic [4:0]  ps_eff;
  logic [21:0] period;
  logic [21:0] open_at;
  logic        tick;
  logic        expire_nxt;
  logic        early_nxt;

  // settings above the top step saturate, keeping the count width bounded
  assign ps_eff     = (ps_in > wdc_pkg::PS_MAX) ? wdc_pkg::PS_MAX : ps_in;
  assign period     = 22'(1) << ps_eff;
  assign open_at    = period - (period >> 2);
  assign tick       = run_in && (tick_r == wdc_pkg::TICK_LAST);
  assign expire_nxt = tick && (count_r == period - 22'(1)) && !clear_in;
  assign early_nxt  = run_in && clear_in && window_in && (count_r < open_at);

  always_ff @(posedge clk_in) begin
    if (!resetn_in || !run_in || tick) begin
      tick_r <= 8'h00;
    end else begin
      tick_r <= tick_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in || !run_in || clear_in || expire_nxt) begin
      count_r <= 22'h00_0000;
    end else if (tick) begin
      count_r <= count_r + 22'h00_0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      expire_out      <= 1'b0;
      early_clear_out <= 1'b0;
    end else begin
      expire_out      <= expire_nxt;
      early_clear_out <= early_nxt;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_clear_zeroes_count: assert property (clear_in |=> count_r == 22'h00_0000)
    else $error("count not cleared by clear strobe");
  a_window_early_trip: assert property (
    (run_in && clear_in && window_in && count_r < open_at) |=> early_clear_out)
    else $error("early clear in window mode not flagged");
  a_expire_at_period: assert property (
    (tick && count_r == period - 22'(1) && !clear_in) |=> expire_out ##1 !expire_out)
    else $error("expiry not a single pulse at period end");

endmodule : wdc_counter

// File: rtl/wdc_top.sv
// module: watchdog control register with apb slave and set/clear/invert aliases

// Function
// - Writing one to bit 15 starts the watchdog if configuration left it off, and writing zero stops it only if software started it.
// - Bit 15 reads one whenever the watchdog runs, enabled by configuration or by software.
// - Bits 6 to 2 are a read-only copy of the postscaler configuration, loaded on every reset.
// - Bit 1 selects windowed operation when set, normal when clear, and resets to zero.
// - Writing one to bit 0 at the plain, set or invert word clears the watchdog count; the clear word and zeros there do nothing.
// - Bits 31 to 16 and 14 to 7 are unimplemented and read as zero.
// - The register has clear, set and invert aliases at offsets 0x4, 0x8 and 0xc above its base.
// - Reset contents follow the configuration inputs rather than one fixed value; the kind of reset does not change them.
module wdc_top (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic        cfg_enable_in,
  input  wire logic [4:0]  postscaler_config_in,
  input  wire logic        por_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             wdt_running_out,
  output logic             device_reset_out
);

  wdc_pkg::wdc_apb_req_type req;

  logic        sw_en_r;
  logic        win_r;
  logic [4:0]  postscaler_shadow_r;
  logic        clear_r;
  logic        por_seen_r;
  logic        running;
  logic [31:0] rd_val;
  logic        addr_ok;
  logic        access;
  logic        wr_take;
  logic [31:0] new_val;
  logic        new_on;
  logic        sw_en_nxt;
  logic        expire;
  logic        early_clear;

  assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in,
                 addr: paddr_in, wdata: pwdata_in};

  assign running = cfg_enable_in || sw_en_r;
  assign rd_val  = {16'h0000, running, 8'h00, postscaler_shadow_r, win_r, 1'b0};

  // only the four aligned words of the control register are mapped
  assign addr_ok = (req.addr[7:4] == 4'h0) && (req.addr[1:0] == 2'b00);
  assign access  = req.sel && req.enable && !pready_out;
  assign wr_take = req.sel && req.enable && pready_out && req.write && addr_ok;

  // alias decode: plain write, clear, set, invert on the read-back value
  assign new_val = (req.addr == wdc_pkg::OFS_CLR) ? (rd_val & ~req.wdata) :
                   (req.addr == wdc_pkg::OFS_SET) ? (rd_val | req.wdata) :
                   (req.addr == wdc_pkg::OFS_INV) ? (rd_val ^ req.wdata) :
                   req.wdata;
  assign new_on  = new_val[wdc_pkg::BIT_ON];

  // configuration enable cannot be undone by software; software enable can
  assign sw_en_nxt = !wr_take ? sw_en_r :
                     (new_on ? !cfg_enable_in || sw_en_r : 1'b0);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sw_en_r             <= wdc_pkg::SW_EN_RESET;
      win_r               <= wdc_pkg::WIN_RESET;
      postscaler_shadow_r <= postscaler_config_in;
    end else begin
      sw_en_r <= sw_en_nxt;
      if (wr_take) begin
        win_r <= new_val[wdc_pkg::BIT_WIN];
      end
    end
  end

  // bit 0 never stores; a one on the plain, set or invert word becomes a one-cycle clear strobe
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      clear_r <= 1'b0;
    end else begin
      clear_r <= wr_take && new_val[wdc_pkg::BIT_CLR];
    end
  end

  // one wait state: pready rises on the first access edge and the transfer ends on the second
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= access;
      pslverr_out <= access && !addr_ok;
      prdata_out  <= (access && !req.write && addr_ok) ? rd_val : 32'h0000_0000;
    end
  end

  // device reset holds until the system reset; por marks a power-on reset kind
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wdt_running_out  <= 1'b0;
      device_reset_out <= 1'b0;
      por_seen_r       <= 1'b0;
    end else begin
      wdt_running_out  <= running;
      device_reset_out <= device_reset_out || expire || early_clear;
      por_seen_r       <= por_seen_r || por_in;
    end
  end

  wdc_counter u_counter (
    .clk_in          (clk_in),
    .resetn_in       (resetn_in),
    .run_in          (running && !device_reset_out),
    .clear_in        (clear_r),
    .window_in       (win_r),
    .ps_in           (postscaler_shadow_r),
    .expire_out      (expire),
    .early_clear_out (early_clear)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_access_wait;
    psel_in && penable_in && !pready_out;
  endsequence

  sequence s_access_done;
    pready_out ##1 !pready_out;
  endsequence

  // unmapped words still finish, flagged, and leave the register alone
  sequence s_bad_access;
    psel_in && penable_in && !pready_out && !addr_ok;
  endsequence

  sequence s_bad_write_done;
    psel_in && penable_in && pready_out && pwrite_in && !addr_ok;
  endsequence

  a_bus_one_wait: assert property (s_access_wait |=> s_access_done)
    else $error("apb answer not after exactly one wait state");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  a_bad_access_err: assert property (s_bad_access |=> pready_out && pslverr_out)
    else $error("unmapped access not answered with an error");
  a_bad_write_kept: assert property (
    s_bad_write_done |=> $stable(win_r) && $stable(sw_en_r))
    else $error("unmapped write changed the register");
  a_error_data_zero: assert property (pslverr_out |-> prdata_out == 32'h0000_0000)
    else $error("error answer carried read data");
  a_prdata_idle: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data shown outside the answer cycle");
  a_on_sw_start: assert property (
    (wr_take && new_on && !cfg_enable_in) |=> sw_en_r)
    else $error("software enable did not start watchdog");
  a_on_sw_stop: assert property ((wr_take && !new_on) |=> !sw_en_r)
    else $error("software enable not cleared by zero write");
  a_cfg_keeps_on: assert property (
    (wr_take && cfg_enable_in) ##1 cfg_enable_in |=> wdt_running_out)
    else $error("software stopped a configuration enabled watchdog");
  a_running_mirror: assert property (
    $past(resetn_in) |-> wdt_running_out == $past(running))
    else $error("running output does not follow the enable");
  a_on_readback: assert property (
    (access && !req.write && addr_ok) |=> prdata_out[15] == $past(running))
    else $error("enable readback does not show running state");
  a_reserved_zero: assert property (pready_out |-> (prdata_out & ~wdc_pkg::IMPL_MASK) == 0)
    else $error("unimplemented bits read nonzero");
  a_field_readback: assert property (
    (access && !req.write && addr_ok) |=>
      prdata_out[6:2] == postscaler_shadow_r && prdata_out[1] == $past(win_r))
    else $error("shadow or window field reads back wrong");
  a_clear_reads_zero: assert property (pready_out |-> !prdata_out[wdc_pkg::BIT_CLR])
    else $error("clear bit read back as one");
  a_shadow_fixed: assert property ($stable(postscaler_shadow_r))
    else $error("postscaler shadow changed outside reset");
  a_alias_clr_win: assert property (
    (wr_take && req.addr == wdc_pkg::OFS_CLR && req.wdata[1]) |=> !win_r)
    else $error("clear alias did not clear window bit");
  a_alias_set_on: assert property (
    (wr_take && req.addr == wdc_pkg::OFS_SET && req.wdata[wdc_pkg::BIT_ON] && !cfg_enable_in)
    |=> sw_en_r)
    else $error("set alias did not start watchdog");
  a_alias_inv_win: assert property (
    (wr_take && req.addr == wdc_pkg::OFS_INV && req.wdata[wdc_pkg::BIT_WIN])
    |=> win_r != $past(win_r))
    else $error("invert alias did not flip window bit");
  a_win_from_write: assert property (
    (wr_take && req.addr == wdc_pkg::OFS_CTRL) |=> win_r == $past(req.wdata[wdc_pkg::BIT_WIN]))
    else $error("window bit not taken from plain write");
  a_clear_strobe: assert property ((wr_take && new_val[0]) |=> clear_r ##1 !clear_r)
    else $error("clear strobe not a single pulse");
  a_zero_no_clear: assert property (
    (wr_take && !req.wdata[wdc_pkg::BIT_CLR]) |=> !clear_r)
    else $error("zero in bit 0 produced a clear strobe");
  a_expire_reset: assert property ((expire || early_clear) |=> device_reset_out [*3])
    else $error("timeout did not hold device reset");
  a_window_reset: assert property (early_clear |=> device_reset_out)
    else $error("window violation did not reset the device");
  a_reset_sticky: assert property (device_reset_out |=> device_reset_out)
    else $error("device reset released without system reset");
  a_por_sticky: assert property (por_in |=> por_seen_r)
    else $error("power-on reset kind not remembered");

  // reset is the trigger here, so it must not disable this one
  property p_reset_loads;
    @(posedge clk_in) disable iff (1'b0)
      !resetn_in |=> postscaler_shadow_r == $past(postscaler_config_in) && !win_r && !sw_en_r;
  endproperty
  a_reset_contents: assert property (p_reset_loads)
    else $error("reset contents not taken from configuration");

endmodule : wdc_top

// File: tb/watchdog_control_bench.sv
// testbench: self-checking apb bench for the watchdog control register
module watchdog_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in, resetn_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd, lf;
  logic        cfg_enable_in, por_in, pready_out, pslverr_out, er;
  logic [4:0]  postscaler_config_in, m_ps;
  logic        wdt_running_out, device_reset_out, m_sw, m_win, m_cfg;
  int          fail_count, checks, n;
  int          cyc = 0;

  wdc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .cfg_enable_in(cfg_enable_in),
    .postscaler_config_in(postscaler_config_in), .por_in(por_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .wdt_running_out(wdt_running_out), .device_reset_out(device_reset_out));

  always #50 clk_in = ~clk_in;

  task automatic summarize();
    $display("mismatches %0d of %0d checks", fail_count, checks);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // hangs are cut here; the whole run needs about 1200 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] exp_reg();
    return {16'h0000, m_cfg | m_sw, 8'h00, m_ps, m_win, 1'b0};
  endfunction : exp_reg

  // aliases act on the read-back value, bit 0 never reads back
  function automatic void model_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = exp_reg();
    case (a)
      8'h00: v = d;
      8'h04: v = v & ~d;
      8'h08: v = v | d;
      default: v = v ^ d;
    endcase
    if (!v[15]) m_sw = 1'b0;
    else if (!m_cfg) m_sw = 1'b1;
    m_win = v[1];
  endfunction : model_wr

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic do_reset(input logic [4:0] ps, input logic cfg);
    resetn_in <= 1'b0;
    postscaler_config_in <= ps;
    cfg_enable_in <= cfg;
    por_in <= lf[3];
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    {m_sw, m_win, m_ps, m_cfg} = {2'b00, ps, cfg};
    @(posedge clk_in);
    chk({31'h0, device_reset_out}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, exp_reg());
  endtask : do_reset

  initial begin
    {clk_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {resetn_in, cfg_enable_in, por_in, postscaler_config_in} = '0;
    {fail_count, checks} = '0;
    lf = 32'hc65b8d2e;
    for (int c = 0; c < 2; c++) begin
      do_reset(lf[4:0], c[0]);
      for (int i = 0; i < 60; i++) begin
        lf = lfsr(lf);
        // every fifth step writes to a place that is both unmapped and unaligned
        if (i % 5 == 4) begin
          apb(1'b1, lf[15:8] | 8'h11, lf);
          chk({31'h0, er}, 32'h1);
          chk(rd, 32'h0);
        end else begin
          apb(1'b1, {4'h0, i[1:0], 2'b00}, lf);
          model_wr({4'h0, i[1:0], 2'b00}, lf);
          chk({31'h0, er}, 32'h0);
          apb(1'b0, {4'h0, lf[9:8], 2'b00}, 32'h0);
          chk(rd, exp_reg());
          chk({31'h0, wdt_running_out}, {31'h0, m_cfg | m_sw});
        end
      end
    end
    // regular clears keep the device alive, then let it expire
    do_reset(5'h02, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_8000);
    for (int i = 0; i < 8; i++) begin
      repeat (15) @(posedge clk_in);
      apb(1'b1, 8'h08, 32'h0000_0001);
      chk({31'h0, device_reset_out}, 32'h0);
    end
    for (n = 0; n < 100 && device_reset_out !== 1'b1; n++) @(posedge clk_in);
    chk({31'h0, device_reset_out}, 32'h1);
    // an early clear in windowed mode must reset the device
    do_reset(5'h02, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_8002);
    apb(1'b1, 8'h08, 32'h0000_0001);
    repeat (3) @(posedge clk_in);
    chk({31'h0, device_reset_out}, 32'h1);
    summarize();
  end
endmodule : watchdog_control_bench
